// ==== hdl/sdcb_pkg.sv ====
// Shared constants and types for the SDRAM command and bank logic
`default_nettype none

package sdcb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 12;
  localparam int DQ_W = 16;
  localparam int LANES = DQ_W / 8;
  localparam int MODE_W = ADDR_W + BA_W;
  localparam int AP_BIT = 10;

  // ----------------------------------------------------------------
  // Command codes as {row strobe, column strobe, write enable}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------
  // Timing at the 50 ns clock; least times round up
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RP_NS = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_RFC_NS = 80;
  localparam int T_MRD_CK = 2;
  localparam int RP_CY = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CY = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC_CY = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRD_CY = T_MRD_CK;
  localparam int WAIT_W = 4;

  // ----------------------------------------------------------------
  // State and request types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDCB_PW_RUN = 3'b001,
    SDCB_PW_SELF = 3'b010,
    SDCB_PW_DEEP = 3'b100
  } sdcb_pw_t;

  typedef enum logic [2:0] {
    SDCB_C_RUN = 3'b001,
    SDCB_C_WAIT = 3'b010,
    SDCB_C_SLEEP = 3'b100
  } sdcb_cst_t;

  typedef enum logic [3:0] {
    SDCB_OP_ACT = 4'h0,
    SDCB_OP_RD = 4'h1,
    SDCB_OP_WR = 4'h2,
    SDCB_OP_PRE = 4'h3,
    SDCB_OP_REF = 4'h4,
    SDCB_OP_SELF = 4'h5,
    SDCB_OP_MODE = 4'h6,
    SDCB_OP_STOP = 4'h7,
    SDCB_OP_DEEP = 4'h8,
    SDCB_OP_WAKE = 4'h9
  } sdcb_op_t;

endpackage : sdcb_pkg

`default_nettype wire

// ==== hdl/sdcb_if.sv ====
// Pin-level link between memory controller and SDRAM device
`default_nettype none

interface sdcb_if import sdcb_pkg::*; ();
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] dqm;
  logic [DQ_W-1:0] ctrl_dq;
  logic ctrl_dq_oe;
  logic [DQ_W-1:0] mem_dq;
  logic [LANES-1:0] mem_dq_oe;
  // Resolved data bus; a lane nobody drives reads as zero
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] dq_driven;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      dq_driven[i] = ctrl_dq_oe | mem_dq_oe[i];
      if (ctrl_dq_oe) begin
        dq[i*8 +: 8] = ctrl_dq[i*8 +: 8];
      end else if (mem_dq_oe[i]) begin
        dq[i*8 +: 8] = mem_dq[i*8 +: 8];
      end else begin
        dq[i*8 +: 8] = 8'h00;
      end
    end
  end

  modport mem (
    input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, ctrl_dq,
    output mem_dq, mem_dq_oe
  );
  modport ctrl (
    output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, ctrl_dq,
    output ctrl_dq_oe,
    input mem_dq, mem_dq_oe
  );
endinterface : sdcb_if

`default_nettype wire

// ==== hdl/sdcb_ctrl.sv ====
// Controller end: issues legal SDRAM commands from user requests
`default_nettype none

module sdcb_ctrl import sdcb_pkg::*; #(
  parameter int BURST_LEN = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Memory pins
  sdcb_if.ctrl pins,
  // Requests
  input wire logic op_valid,
  input wire sdcb_op_t op_code,
  input wire logic [BA_W-1:0] op_ba,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [LANES-1:0] op_dqm,
  input wire logic [DQ_W-1:0] wr_data,
  output logic op_ready,
  output logic op_refused,
  // Read return
  output logic [DQ_W-1:0] rd_data,
  output logic [LANES-1:0] rd_lanes
);

  localparam logic [WAIT_W-1:0] WB_LAST = WAIT_W'(BURST_LEN - 1);

  sdcb_cst_t st_r;
  logic [WAIT_W-1:0] wait_r;
  logic [WAIT_W-1:0] wb_r;
  logic [BANKS-1:0] open_r;
  logic legal;
  logic take;
  logic [WAIT_W-1:0] hold;

  always_comb begin
    legal = 1'b0;
    hold = WAIT_W'(1);
    if (st_r == SDCB_C_SLEEP) begin
      legal = (op_code == SDCB_OP_WAKE);
      hold = WAIT_W'(RFC_CY);
    end else begin
      case (op_code)
        SDCB_OP_ACT: begin
          legal = !open_r[op_ba];
          hold = WAIT_W'(RCD_CY);
        end
        SDCB_OP_RD, SDCB_OP_WR: legal = open_r[op_ba];
        SDCB_OP_PRE: begin
          legal = 1'b1;
          hold = WAIT_W'(RP_CY);
        end
        SDCB_OP_REF: begin
          legal = (open_r == '0);
          hold = WAIT_W'(RFC_CY);
        end
        SDCB_OP_MODE: begin
          legal = (open_r == '0);
          hold = WAIT_W'(MRD_CY);
        end
        SDCB_OP_SELF, SDCB_OP_DEEP: legal = (open_r == '0);
        SDCB_OP_STOP: legal = 1'b1;
        default: legal = 1'b0;
      endcase
    end
  end

  assign take = clk_en && op_valid && op_ready && legal;

  // ----------------------------------------------------------------
  // Pacing: only inhibit is issued while a wait runs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= SDCB_C_RUN;
      wait_r <= '0;
      op_ready <= 1'b1;
      op_refused <= 1'b0;
    end else if (clk_en) begin
      op_refused <= op_valid && op_ready && !legal;
      case (st_r)
        SDCB_C_RUN, SDCB_C_SLEEP: begin
          if (take) begin
            if (op_code == SDCB_OP_SELF || op_code == SDCB_OP_DEEP) begin
              st_r <= SDCB_C_SLEEP;
            end else if (hold > WAIT_W'(1)) begin
              st_r <= SDCB_C_WAIT;
              wait_r <= hold - WAIT_W'(1);
              op_ready <= 1'b0;
            end else begin
              st_r <= SDCB_C_RUN;
            end
          end
        end
        SDCB_C_WAIT: begin
          wait_r <= wait_r - WAIT_W'(1);
          if (wait_r == WAIT_W'(1)) begin
            st_r <= SDCB_C_RUN;
            op_ready <= 1'b1;
          end
        end
        default: st_r <= SDCB_C_RUN;
      endcase
    end
  end

  // Bank bookkeeping mirrors what the device will do
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      open_r <= '0;
    end else if (clk_en && take) begin
      case (op_code)
        SDCB_OP_ACT: open_r[op_ba] <= 1'b1;
        SDCB_OP_PRE: begin
          if (op_addr[AP_BIT]) begin
            open_r <= '0;
          end else begin
            open_r[op_ba] <= 1'b0;
          end
        end
        SDCB_OP_RD, SDCB_OP_WR: begin
          if (op_addr[AP_BIT]) begin
            open_r[op_ba] <= 1'b0;
          end
        end
        default: open_r <= open_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins.cs_n <= 1'b1;
      {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
      pins.cke <= 1'b1;
      pins.ba <= '0;
      pins.addr <= '0;
    end else if (clk_en) begin
      pins.cs_n <= !take;
      pins.ba <= op_ba;
      pins.addr <= op_addr;
      {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
      if (take) begin
        case (op_code)
          SDCB_OP_ACT: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_ACT;
          SDCB_OP_RD: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_RD;
          SDCB_OP_WR: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_WR;
          SDCB_OP_PRE: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_PRE;
          SDCB_OP_REF, SDCB_OP_SELF: begin
            {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_REF;
          end
          SDCB_OP_MODE: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_MODE;
          SDCB_OP_STOP, SDCB_OP_DEEP: begin
            {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_STOP;
          end
          default: {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
        endcase
        if (op_code == SDCB_OP_SELF || op_code == SDCB_OP_DEEP) begin
          pins.cke <= 1'b0;
        end else if (op_code == SDCB_OP_WAKE) begin
          pins.cke <= 1'b1;
        end
      end
    end
  end

  // Write data rides with the command and each following beat
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_r <= '0;
      pins.ctrl_dq <= '0;
      pins.ctrl_dq_oe <= 1'b0;
      pins.dqm <= '0;
    end else if (clk_en) begin
      pins.ctrl_dq <= wr_data;
      pins.dqm <= op_dqm;
      if (take && op_code == SDCB_OP_WR) begin
        wb_r <= WB_LAST;
        pins.ctrl_dq_oe <= 1'b1;
      end else if (wb_r != '0) begin
        wb_r <= wb_r - WAIT_W'(1);
        pins.ctrl_dq_oe <= 1'b1;
      end else begin
        pins.ctrl_dq_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
      rd_lanes <= '0;
    end else if (clk_en) begin
      rd_data <= pins.mem_dq;
      rd_lanes <= pins.mem_dq_oe;
    end
  end

endmodule // sdcb_ctrl

`default_nettype wire

// ==== hdl/sdcb_mem.sv ====
// Device end: command decode, bank rows, bursts and a small array
`default_nettype none

// How it works
// - All pins sampled on rising clock edge
// - Activate opens bank row before access
// - Chip select high ignores every command
// - No-op changes nothing, bursts continue
// - Strobes decode into the seven commands
// - Clock enable high, except self/deep sleep
// - Refresh uses internal row counter
// - A10 selects auto close per access
// - Auto close shuts row after last beat
// - Precharge closes one bank or all
// - Mode load stores address and bank bits
// - Mode load only when idle, then wait
// - Precharge before activating another row
// - Closed bank needs activate before access
// - Burst columns generated from start column
// - Read mask floats lane two clocks later
// - Write mask blocks lane same cycle
// - Write data starts on command cycle
// - Burst terminate cuts latest burst
// - New column accepted every cycle
// - After refresh only no-ops until done
// - Deep sleep from idle, leave via enable
module sdcb_mem import sdcb_pkg::*; #(
  parameter int BURST_LEN = 4,
  parameter bit PAGE_BURST = 1'b0,
  parameter bit SEQ_ORDER = 1'b1,
  parameter int CAS_LAT = 2,
  parameter int MEM_ROW_W = 2,
  parameter int MEM_COL_W = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Memory pins
  sdcb_if.mem pins,
  // Status
  output logic [MODE_W-1:0] mode_word,
  output logic [BANKS-1:0] bank_open,
  output logic [ADDR_W-1:0] refresh_row,
  output logic awake
);

  localparam int CW = MEM_COL_W;
  localparam int IW = BA_W + MEM_ROW_W + CW;
  localparam int DEPTH = 1 << IW;
  localparam logic [CW-1:0] BL_LAST = CW'(BURST_LEN - 1);
  localparam int PIPE = CAS_LAT - 1;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sdcb_pw_t pw_r;
  logic [2:0] code;
  logic run_cmd;
  logic is_act;
  logic is_rw;
  logic is_pre;
  logic is_ref;
  logic is_mode;
  logic is_stop;
  logic pre_hit;

  // Pins are used only at the rising edge, by the flops below
  assign code = {pins.ras_n, pins.cas_n, pins.we_n};
  assign run_cmd = pw_r[0] && !pins.cs_n && pins.cke;
  assign is_act = run_cmd && code == CMD_ACT;
  // Access to a closed bank is dropped, not guessed at
  assign is_rw = run_cmd && (code == CMD_RD || code == CMD_WR)
    && bank_open[pins.ba];
  assign is_pre = run_cmd && code == CMD_PRE;
  assign is_ref = run_cmd && code == CMD_REF;
  assign is_mode = run_cmd && code == CMD_MODE;
  assign is_stop = run_cmd && code == CMD_STOP;
  // No-op and inhibit fall through every branch above

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pw_r <= SDCB_PW_RUN;
    end else if (clk_en) begin
      case (pw_r)
        SDCB_PW_RUN: begin
          if (!pins.cs_n && !pins.cke && code == CMD_REF) begin
            pw_r <= SDCB_PW_SELF;
          end else if (!pins.cs_n && !pins.cke && code == CMD_STOP) begin
            pw_r <= SDCB_PW_DEEP;
          end
        end
        SDCB_PW_SELF, SDCB_PW_DEEP: begin
          if (pins.cke) begin
            pw_r <= SDCB_PW_RUN;
          end
        end
        default: pw_r <= SDCB_PW_RUN;
      endcase
    end
  end

  assign awake = pw_r[0];

  // Row counter steps on every auto refresh and on self refresh entry
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      refresh_row <= '0;
    end else if (clk_en) begin
      if (is_ref || (pw_r[0] && !pins.cs_n && !pins.cke
          && code == CMD_REF)) begin
        refresh_row <= refresh_row + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_word <= '0;
    end else if (clk_en && is_mode) begin
      mode_word <= {pins.ba, pins.addr};
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  logic bst_act_r;
  logic bst_wr_r;
  logic bst_ap_r;
  logic [BA_W-1:0] bst_bank_r;
  logic [CW-1:0] bst_base_r;
  logic [CW-1:0] bst_idx_r;
  logic beat_go;
  logic beat_wr;
  logic beat_ap;
  logic beat_last;
  logic [BA_W-1:0] beat_bank;
  logic [CW-1:0] beat_base;
  logic [CW-1:0] beat_idx;
  logic [CW-1:0] beat_col;
  logic [ADDR_W-1:0] row_r [BANKS];

  assign pre_hit = is_pre && (pins.addr[AP_BIT] || pins.ba == bst_bank_r);

  always_comb begin
    beat_go = 1'b0;
    beat_wr = bst_wr_r;
    beat_ap = bst_ap_r;
    beat_bank = bst_bank_r;
    beat_base = bst_base_r;
    beat_idx = bst_idx_r;
    if (is_rw) begin
      // A fresh column preempts whatever burst was running
      beat_go = 1'b1;
      beat_wr = (code == CMD_WR);
      beat_ap = pins.addr[AP_BIT];
      beat_bank = pins.ba;
      beat_base = pins.addr[CW-1:0];
      beat_idx = '0;
    end else if (bst_act_r && !is_stop && !pre_hit) begin
      beat_go = 1'b1;
    end
    if (PAGE_BURST) begin
      beat_col = beat_base + beat_idx;
    end else if (SEQ_ORDER) begin
      beat_col = (beat_base & ~BL_LAST)
        | ((beat_base + beat_idx) & BL_LAST);
    end else begin
      beat_col = beat_base ^ beat_idx;
    end
    beat_last = !PAGE_BURST && beat_idx == BL_LAST;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_ap_r <= 1'b0;
      bst_bank_r <= '0;
      bst_base_r <= '0;
      bst_idx_r <= '0;
    end else if (clk_en) begin
      bst_act_r <= beat_go && !beat_last;
      if (beat_go) begin
        bst_wr_r <= beat_wr;
        bst_ap_r <= beat_ap;
        bst_bank_r <= beat_bank;
        bst_base_r <= beat_base;
        bst_idx_r <= beat_idx + CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank rows
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bank_open <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_r[b] <= '0;
      end
    end else if (clk_en) begin
      for (int b = 0; b < BANKS; b++) begin
        if (is_act && pins.ba == BA_W'(b)) begin
          bank_open[b] <= 1'b1;
          row_r[b] <= pins.addr;
        end else if (is_pre && (pins.addr[AP_BIT]
            || pins.ba == BA_W'(b))) begin
          bank_open[b] <= 1'b0;
        end else if (beat_go && beat_last && beat_ap
            && beat_bank == BA_W'(b)) begin
          bank_open[b] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Array, one byte lane per generate pass
  // ----------------------------------------------------------------
  logic [IW-1:0] beat_index;
  logic [DQ_W-1:0] array_q;

  assign beat_index = {beat_bank, row_r[beat_bank][MEM_ROW_W-1:0],
    beat_col};

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] lane_q [DEPTH];
    always_ff @(posedge core_clk) begin
      if (clk_en && beat_go && beat_wr && !pins.dqm[g]) begin
        lane_q[beat_index] <= pins.ctrl_dq[g*8 +: 8];
      end
    end
    assign array_q[g*8 +: 8] = lane_q[beat_index];
  end

  // ----------------------------------------------------------------
  // Read return: latency line plus two-clock mask
  // ----------------------------------------------------------------
  logic rd_v_r [PIPE];
  logic [DQ_W-1:0] rd_d_r [PIPE];
  logic [LANES-1:0] dqm_d1_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < PIPE; s++) begin
        rd_v_r[s] <= 1'b0;
        rd_d_r[s] <= '0;
      end
      dqm_d1_r <= '0;
      pins.mem_dq <= '0;
      pins.mem_dq_oe <= '0;
    end else if (clk_en) begin
      rd_v_r[0] <= beat_go && !beat_wr;
      rd_d_r[0] <= array_q;
      for (int s = 1; s < PIPE; s++) begin
        rd_v_r[s] <= rd_v_r[s-1];
        rd_d_r[s] <= rd_d_r[s-1];
      end
      dqm_d1_r <= pins.dqm;
      pins.mem_dq <= rd_d_r[PIPE-1];
      pins.mem_dq_oe <= {LANES{rd_v_r[PIPE-1]}} & ~dqm_d1_r;
    end
  end

endmodule // sdcb_mem

`default_nettype wire

// ==== tb/sdcb_chk.sv ====
// Pin-level protocol checks on the link between the two ends
`default_nettype none

module sdcb_chk import sdcb_pkg::*; #(
  parameter int BURST_LEN = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // Data lane control
  input wire logic [LANES-1:0] dqm,
  input wire logic ctrl_dq_oe,
  input wire logic [LANES-1:0] mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Decode and bank tracking
  // ----------------------------------------------------------------
  wire [2:0] code = {ras_n, cas_n, we_n};
  wire go = !cs_n && cke;
  wire act_c = go && code == CMD_ACT;
  wire rd_c = go && code == CMD_RD, wr_c = go && code == CMD_WR;
  wire pre_c = go && code == CMD_PRE, stop_c = go && code == CMD_STOP;
  wire idle_c = go && (code == CMD_MODE || code == CMD_REF);
  logic [BANKS-1:0] open_r;
  logic [3:0] age_r;

  // Auto close counts as closed at the command, as the controller sees it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      open_r <= '0;
    end else if (act_c) begin
      open_r[ba] <= 1'b1;
    end else if (pre_c && addr[AP_BIT]) begin
      open_r <= '0;
    end else if (pre_c || ((rd_c || wr_c) && addr[AP_BIT])) begin
      open_r[ba] <= 1'b0;
    end
  end

  // Edges since the last read; saturates so a stale read never matches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      age_r <= 4'hF;
    end else if (rd_c) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions (read latency of two clocks assumed)
  // ----------------------------------------------------------------
  sequence quiet_s;
    cs_n || code == CMD_NOP;
  endsequence
  // Four beats: the default burst length
  sequence wr_beats_s;
    ctrl_dq_oe [*4];
  endsequence

  chk_read_lane_mask: assert property (rd_c |-> ##2
    mem_dq_oe == ~$past(dqm, 2)) else $error("read lane enable wrong");
  chk_drive_window: assert property (|mem_dq_oe |->
    age_r >= 4'h1 && age_r <= 4'(BURST_LEN)) else $error("stray read drive");
  chk_write_beats: assert property (wr_c |-> wr_beats_s)
    else $error("write data not driven for the burst");
  chk_single_driver: assert property (ctrl_dq_oe |->
    mem_dq_oe == '0) else $error("both ends drive the data bus");
  chk_stop_cuts: assert property (stop_c |-> ##2
    mem_dq_oe == '0) else $error("read beat after burst stop");
  chk_idle_banks: assert property (idle_c |-> open_r == '0)
    else $error("mode load or refresh with a bank open");
  chk_idle_after: assert property (idle_c |=> quiet_s)
    else $error("command too soon after mode load or refresh");
  chk_act_closed: assert property (act_c |-> !open_r[ba])
    else $error("activate to an open bank");
  chk_access_open: assert property ((rd_c || wr_c) |-> open_r[ba])
    else $error("access to a closed bank");
  chk_sleep_entry: assert property ($fell(cke) |-> !cs_n &&
    (code == CMD_REF || code == CMD_STOP)) else $error("bad sleep entry");
  chk_wake_quiet: assert property ($rose(cke) |->
    quiet_s ##1 quiet_s) else $error("command too soon after wake");
endmodule // sdcb_chk

`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench joining controller and device ends over the pin link
`default_nettype none

module tb_top import sdcb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BL = 4;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  sdcb_op_t op_code = SDCB_OP_ACT;
  logic [BA_W-1:0] op_ba = '0;
  logic [ADDR_W-1:0] op_addr = '0;
  logic [LANES-1:0] op_dqm = '0;
  logic [DQ_W-1:0] wr_data = '0;
  logic op_ready, op_refused, awake;
  logic [DQ_W-1:0] rd_data;
  logic [LANES-1:0] rd_lanes;
  logic [MODE_W-1:0] mode_word;
  logic [BANKS-1:0] bank_open;
  logic [ADDR_W-1:0] refresh_row;
  logic clk_en = 1'b1;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'hD3D07A45;
  logic [DQ_W-1:0] mdl [8];
  logic [DQ_W-1:0] bd [4] = '{default: '0};
  logic [LANES-1:0] bm [4] = '{default: '0};
  logic [DQ_W-1:0] rq [4];
  logic [LANES-1:0] rl [4];

  sdcb_if pins ();
  always #25 core_clk = ~core_clk;

  sdcb_ctrl #(.BURST_LEN(BL)) i_sdcb_ctrl (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .pins(pins),
    .op_valid(op_valid), .op_code(op_code), .op_ba(op_ba),
    .op_addr(op_addr), .op_dqm(op_dqm), .wr_data(wr_data),
    .op_ready(op_ready), .op_refused(op_refused),
    .rd_data(rd_data), .rd_lanes(rd_lanes));
  sdcb_mem #(.BURST_LEN(BL)) i_sdcb_mem (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .pins(pins),
    .mode_word(mode_word), .bank_open(bank_open),
    .refresh_row(refresh_row), .awake(awake));
  sdcb_chk #(.BURST_LEN(BL)) i_sdcb_chk (
    .core_clk(core_clk), .rst(rst), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
    .cas_n(pins.cas_n), .we_n(pins.we_n), .cke(pins.cke), .ba(pins.ba),
    .addr(pins.addr), .dqm(pins.dqm), .ctrl_dq_oe(pins.ctrl_dq_oe),
    .mem_dq_oe(pins.mem_dq_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ready();
    for (int n = 0; op_ready !== 1'b1; n++) begin
      if (n == 20) begin
        $display("wrong value op_ready expected 1 seen %b", op_ready);
        num_errors++;
        stop_test();
      end
      @(negedge core_clk);
    end
  endtask

  // Beat i data and mask are sampled at the take edge plus i; reads are
  // captured n cycles on, three cycles after their beat
  task automatic issue(sdcb_op_t op, logic [BA_W-1:0] b,
    logic [ADDR_W-1:0] a, int n);
    wait_ready();
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_ba <= b;
    op_addr <= a;
    wr_data <= bd[0];
    op_dqm <= bm[0];
    for (int j = 0; j <= n; j++) begin
      @(posedge core_clk);
      op_valid <= 1'b0;
      wr_data <= (j < 3) ? bd[j + 1] : '0;
      op_dqm <= (j < 3) ? bm[j + 1] : '0;
      @(negedge core_clk);
      if (j >= 3) begin
        rq[j - 3] = rd_data;
        rl[j - 3] = rd_lanes;
      end
    end
  endtask

  function automatic int bcol(int c, int i);
    return (c & ~(BL - 1)) | ((c + i) & (BL - 1));
  endfunction
  function automatic logic [DQ_W-1:0] lmask(logic [LANES-1:0] m);
    for (int l = 0; l < LANES; l++) begin
      lmask[l*8 +: 8] = {8{!m[l]}};
    end
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int b, c, cnt;
    logic [ADDR_W-1:0] r0;
    logic [DQ_W-1:0] m;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(negedge core_clk);
    check("bank_open", 0, bank_open);
    check("awake", 1, awake);
    r0 = ADDR_W'($random(seed));
    b = $random(seed) & 3;
    issue(SDCB_OP_MODE, BA_W'(b), r0, 0);
    repeat (2) @(negedge core_clk);
    check("mode_word", {BA_W'(b), r0}, mode_word);
    r0 = refresh_row;
    issue(SDCB_OP_REF, 0, 0, 0);
    repeat (3) @(negedge core_clk);
    check("refresh_row", ADDR_W'(r0 + 1), refresh_row);
    $display("test mode and refresh done");
    for (int i = 0; i < BANKS; i++) begin
      issue(SDCB_OP_ACT, BA_W'(i), ADDR_W'($random(seed)), 0);
    end
    @(negedge core_clk);
    check("all open", 4'hF, bank_open);
    @(posedge core_clk);
    clk_en <= 1'b0;
    issue(SDCB_OP_PRE, 2'h0, 12'h400, 0);
    check("frozen banks", 4'hF, bank_open);
    @(posedge core_clk);
    clk_en <= 1'b1;
    issue(SDCB_OP_PRE, 2'h1, 12'h000, 0);
    @(negedge core_clk);
    check("one closed", 4'hD, bank_open);
    issue(SDCB_OP_PRE, 2'h1, 12'h400, 0);
    @(negedge core_clk);
    check("all closed", 4'h0, bank_open);
    $display("test bank open and close done");
    for (int k = 0; k < 3; k++) begin
      b = $random(seed) & 3;
      issue(SDCB_OP_ACT, BA_W'(b), ADDR_W'($random(seed)), 0);
      // Two full writes fill the row model, then a masked one lands
      for (int h = 0; h < 3; h++) begin
        c = (h < 2) ? h * 4 : ((k == 0) ? 7 : $random(seed) & 7);
        for (int i = 0; i < 4; i++) begin
          bd[i] = DQ_W'($random(seed));
          bm[i] = (h < 2) ? 2'h0 : LANES'($random(seed));
          for (int l = 0; l < LANES; l++) begin
            if (!bm[i][l]) begin
              mdl[bcol(c, i)][l*8 +: 8] = bd[i][l*8 +: 8];
            end
          end
        end
        issue(SDCB_OP_WR, BA_W'(b), ADDR_W'(c), 2);
      end
      check("bank kept open", 1, bank_open[b]);
      c = $random(seed) & 7;
      for (int i = 0; i < 4; i++) begin
        bm[i] = LANES'($random(seed));
      end
      issue(SDCB_OP_RD, BA_W'(b), ADDR_W'(c) | 12'h400, 6);
      for (int i = 0; i < 4; i++) begin
        m = lmask(bm[i]);
        check("read lanes", LANES'(~bm[i]), rl[i]);
        check("read data", mdl[bcol(c, i)] & m, rq[i] & m);
      end
      check("bank auto closed", 0, bank_open[b]);
    end
    $display("test write and read done");
    issue(SDCB_OP_ACT, 2'h2, 12'h000, 0);
    bm = '{default: '0};
    issue(SDCB_OP_RD, 2'h2, 12'h000, 0);
    issue(SDCB_OP_STOP, 2'h2, 12'h000, 0);
    cnt = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      cnt += (rd_lanes != 2'h0);
    end
    check("beats before stop", 2, cnt);
    issue(SDCB_OP_PRE, 2'h0, 12'h400, 0);
    issue(SDCB_OP_RD, 2'h3, 12'h000, 0);
    check("op_refused", 1, op_refused);
    $display("test stop and refusal done");
    for (int s = 0; s < 2; s++) begin
      issue(s ? SDCB_OP_DEEP : SDCB_OP_SELF, 0, 0, 0);
      repeat (2) @(negedge core_clk);
      check("asleep", 0, awake);
      issue(SDCB_OP_WAKE, 0, 0, 0);
      repeat (2) @(negedge core_clk);
      check("woken", 1, awake);
    end
    $display("test sleep modes done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
